// file: inc/cfg_jtag_map.vh
/*
  Shared constants for the configuration and test-access pin block:
  test-controller state codes, instruction codes, sync reset levels and timing.
  Assumes the includer runs on a 20 MHz system clock.
*/
`ifndef CFG_JTAG_MAP_VH
`define CFG_JTAG_MAP_VH

// system clock rate
`define SYS_CLK_HZ 20000000
// least reconfiguration request low time, in ns, and in whole cycles (rounded up)
`define RECFG_LOW_MIN_NS 320
`define RECFG_LOW_MIN_CYC ((`RECFG_LOW_MIN_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)
// least wait from request release to first passive data, in us
`define RECFG_TO_DATA_MIN_US 32

// sixteen-state test controller codes
`define TAP_EXIT2_DR 4'h0
`define TAP_EXIT1_DR 4'h1
`define TAP_SHIFT_DR 4'h2
`define TAP_PAUSE_DR 4'h3
`define TAP_SEL_IR 4'h4
`define TAP_UPDATE_DR 4'h5
`define TAP_CAPTURE_DR 4'h6
`define TAP_SEL_DR 4'h7
`define TAP_EXIT2_IR 4'h8
`define TAP_EXIT1_IR 4'h9
`define TAP_SHIFT_IR 4'hA
`define TAP_PAUSE_IR 4'hB
`define TAP_IDLE 4'hC
`define TAP_UPDATE_IR 4'hD
`define TAP_CAPTURE_IR 4'hE
`define TAP_RESET 4'hF

// instruction codes
`define INS_BYPASS 4'hF
`define INS_ENTER_USER 4'h7
`define INS_READ_SUM 4'h3
// value loaded into the instruction shifter on capture
`define IR_CAPTURE_VAL 4'h1

// synchroniser reset levels {tdi, tms, tck, config_done, recfg_n}
`define SYNC_RST_VAL 5'h19

`endif

// file: src/word_fifo.v
/*
  Synchronous FIFO with a registered output stage; width and depth are parameters.
  Assumes both sides share clk; flush empties it in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst,
	input wire flush,
	// fill side
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// drain side
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	// memory holds DEPTH-1 words, the output stage one more: DEPTH in all
	assign in_ready = (cnt_q < DEPTH - 1) && !flush;
	assign push = in_valid && in_ready;
	assign pop = (cnt_q != 0) && (!out_valid || out_ready);

	// memory write; no reset so it maps onto plain storage
	always @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers, count and the output register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else if (flush) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
				out_data <= mem[rd_q];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

endmodule

`default_nettype wire

// file: src/cfg_tap_port.v
/*
  Configuration-done / reconfiguration-request pin logic plus a four-wire test port.
  Assumes all pins are asynchronous to clk and the test clock is far slower than clk;
  open-drain and tri-state resolution is done outside, from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfg_jtag_map.vh"

// Function
// - open-drain done pin, low while configuring
// - external low on done blocks user mode
// - request reloads configuration, never resets user logic
// - configuration and test pins stay dedicated
// - sample mode-select and data on rising clock
// - update test output after falling clock
// - floating mode-select and data read as one
// - shift into instruction or selected data register
// - output lags input by path length
// - test output undriven when not shifting
// - enter-user instruction then user wait time
module cfg_tap_port #(
	parameter IR_LEN = 4,
	parameter DR_LEN = 8,
	parameter DATA_W = 8,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3,
	parameter CFG_WORDS = 16,
	parameter LOAD_GAP = 4,
	parameter USER_WAIT = 64
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// configuration pins
	input wire recfg_n_pin,
	input wire config_done_pin_in,
	output wire config_done_pin_out,
	output wire config_done_pin_oe,
	// test port pins
	input wire tck_pin,
	input wire tms_pin,
	input wire tdi_pin,
	output wire tdo_pin_out,
	output wire tdo_pin_oe,
	// configuration data stream
	input wire [DATA_W-1:0] cfg_data,
	input wire cfg_valid,
	output wire cfg_ready,
	// mode and status
	input wire cfg_via_tap,
	output wire configuring,
	output wire user_mode
);

	localparam CF_LOAD = 3'd0;
	localparam CF_DONE = 3'd1;
	localparam CF_WAIT = 3'd2;
	localparam CF_USER = 3'd3;
	localparam integer LOW_MIN = `RECFG_LOW_MIN_CYC;

	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg tck_d_q;
	reg recfg_d_q;
	reg [7:0] low_cnt_q;
	reg [2:0] cf_q;
	reg [2:0] cf_d;
	reg [15:0] word_cnt_q;
	reg [7:0] gap_q;
	reg [15:0] wait_q;
	reg enter_user_q;
	reg [DATA_W-1:0] sum_q;
	reg [3:0] tap_q;
	reg [3:0] tap_d;
	reg [IR_LEN-1:0] ir_sh_q;
	reg [IR_LEN-1:0] ir_q;
	reg [DR_LEN-1:0] dr_sh_q;
	reg byp_q;
	reg tdo_q;
	reg tdo_oe_q;
	wire recfg_s;
	wire done_s;
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire tck_rise;
	wire tck_fall;
	wire trigger;
	wire [DATA_W-1:0] fifo_data;
	wire fifo_valid;
	wire fifo_take;
	wire sel_sum;

	// two-flop synchronisers; tms and tdi rest at one like the weak pull-ups
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= `SYNC_RST_VAL;
			sync2_q <= `SYNC_RST_VAL;
		end else begin
			sync1_q <= {tdi_pin, tms_pin, tck_pin, config_done_pin_in, recfg_n_pin};
			sync2_q <= sync1_q;
		end
	end

	assign recfg_s = sync2_q[0];
	assign done_s = sync2_q[1];
	assign tck_s = sync2_q[2];
	assign tms_s = sync2_q[3];
	assign tdi_s = sync2_q[4];

	// edge finders on synchronised levels only
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_d_q <= 1'b0;
			recfg_d_q <= 1'b1;
		end else begin
			tck_d_q <= tck_s;
			recfg_d_q <= recfg_s;
		end
	end

	assign tck_rise = tck_s && !tck_d_q;
	assign tck_fall = !tck_s && tck_d_q;

	// low-time counter; a glitch shorter than the least pulse is ignored
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			low_cnt_q <= 8'h00;
		end else if (recfg_s) begin
			low_cnt_q <= 8'h00;
		end else if (low_cnt_q != LOW_MIN) begin
			low_cnt_q <= low_cnt_q + 8'h01;
		end
	end

	// the release edge of a long-enough low pulse starts a reload
	assign trigger = recfg_s && !recfg_d_q && (low_cnt_q == LOW_MIN);

	// incoming configuration words; the loader drains slowly so back-pressure is real
	assign fifo_take = fifo_valid && (cf_q == CF_LOAD) && (gap_q == 8'h00);

	word_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.flush(trigger),
		.in_data(cfg_data),
		.in_valid(cfg_valid),
		.in_ready(cfg_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);

	// configuration sequencer next state
	always @* begin
		cf_d = cf_q;
		case (cf_q)
			CF_LOAD: begin
				if (fifo_take && word_cnt_q == CFG_WORDS - 1) begin
					cf_d = CF_DONE;
				end
			end
			CF_DONE: begin
				if (done_s && (!cfg_via_tap || enter_user_q)) begin
					cf_d = CF_WAIT;
				end
			end
			CF_WAIT: begin
				if (!done_s) begin
					cf_d = CF_DONE;
				end else if (wait_q == USER_WAIT - 1) begin
					cf_d = CF_USER;
				end
			end
			CF_USER: begin
				if (!done_s) begin
					cf_d = CF_DONE;
				end
			end
			default: begin
				cf_d = CF_LOAD;
			end
		endcase
		if (trigger) begin
			cf_d = CF_LOAD;
		end
	end

	// sequencer registers; the request only restarts loading, user outputs are not reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cf_q <= CF_LOAD;
			word_cnt_q <= 16'h0000;
			gap_q <= 8'h00;
			wait_q <= 16'h0000;
			sum_q <= {DATA_W{1'b0}};
		end else begin
			cf_q <= cf_d;
			if (trigger) begin
				word_cnt_q <= 16'h0000;
				gap_q <= 8'h00;
				sum_q <= {DATA_W{1'b0}};
			end else if (fifo_take) begin
				word_cnt_q <= word_cnt_q + 16'h0001;
				gap_q <= LOAD_GAP[7:0] - 8'h01;
				sum_q <= sum_q ^ fifo_data;
			end else if (gap_q != 8'h00) begin
				gap_q <= gap_q - 8'h01;
			end
			wait_q <= (cf_q == CF_WAIT && cf_d == CF_WAIT) ? wait_q + 16'h0001 : 16'h0000;
		end
	end

	// enter-user request latched from the instruction update; a set beats a reload clear
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			enter_user_q <= 1'b0;
		end else if (tck_rise && tap_q == `TAP_UPDATE_IR && ir_sh_q == `INS_ENTER_USER) begin
			enter_user_q <= 1'b1;
		end else if (trigger) begin
			enter_user_q <= 1'b0;
		end
	end

	// done pin only ever pulls low; released once loading ends
	assign config_done_pin_out = 1'b0;
	assign config_done_pin_oe = (cf_q == CF_LOAD);
	assign configuring = (cf_q == CF_LOAD);
	assign user_mode = (cf_q == CF_USER);

	// test controller next state from the sampled mode-select
	always @* begin
		case (tap_q)
			`TAP_RESET: tap_d = tms_s ? `TAP_RESET : `TAP_IDLE;
			`TAP_IDLE: tap_d = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
			`TAP_SEL_DR: tap_d = tms_s ? `TAP_SEL_IR : `TAP_CAPTURE_DR;
			`TAP_CAPTURE_DR: tap_d = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
			`TAP_SHIFT_DR: tap_d = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
			`TAP_EXIT1_DR: tap_d = tms_s ? `TAP_UPDATE_DR : `TAP_PAUSE_DR;
			`TAP_PAUSE_DR: tap_d = tms_s ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
			`TAP_EXIT2_DR: tap_d = tms_s ? `TAP_UPDATE_DR : `TAP_SHIFT_DR;
			`TAP_UPDATE_DR: tap_d = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
			`TAP_SEL_IR: tap_d = tms_s ? `TAP_RESET : `TAP_CAPTURE_IR;
			`TAP_CAPTURE_IR: tap_d = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
			`TAP_SHIFT_IR: tap_d = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
			`TAP_EXIT1_IR: tap_d = tms_s ? `TAP_UPDATE_IR : `TAP_PAUSE_IR;
			`TAP_PAUSE_IR: tap_d = tms_s ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
			`TAP_EXIT2_IR: tap_d = tms_s ? `TAP_UPDATE_IR : `TAP_SHIFT_IR;
			`TAP_UPDATE_IR: tap_d = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
			default: tap_d = `TAP_RESET;
		endcase
	end

	assign sel_sum = (ir_q == `INS_READ_SUM);

	// rising test-clock work: step the controller, capture, shift, update
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tap_q <= `TAP_RESET;
			ir_sh_q <= {IR_LEN{1'b0}};
			ir_q <= `INS_BYPASS;
			dr_sh_q <= {DR_LEN{1'b0}};
			byp_q <= 1'b0;
		end else if (tck_rise) begin
			tap_q <= tap_d;
			case (tap_q)
				`TAP_RESET: ir_q <= `INS_BYPASS;
				`TAP_CAPTURE_IR: ir_sh_q <= `IR_CAPTURE_VAL;
				`TAP_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[IR_LEN-1:1]};
				`TAP_UPDATE_IR: ir_q <= ir_sh_q;
				`TAP_CAPTURE_DR: begin
					dr_sh_q <= sel_sum ? sum_q : {DR_LEN{1'b0}};
					byp_q <= 1'b0;
				end
				`TAP_SHIFT_DR: begin
					if (sel_sum) begin
						dr_sh_q <= {tdi_s, dr_sh_q[DR_LEN-1:1]};
					end else begin
						byp_q <= tdi_s;
					end
				end
				default: begin
					byp_q <= byp_q;
				end
			endcase
		end
	end

	// falling test-clock work: launch the path's last bit, drive only while shifting
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			if (tap_q == `TAP_SHIFT_IR) begin
				tdo_q <= ir_sh_q[0];
			end else begin
				tdo_q <= sel_sum ? dr_sh_q[0] : byp_q;
			end
			tdo_oe_q <= (tap_q == `TAP_SHIFT_IR) || (tap_q == `TAP_SHIFT_DR);
		end
	end

	assign tdo_pin_out = tdo_q;
	assign tdo_pin_oe = tdo_oe_q;

endmodule

`default_nettype wire

// file: testbench/cfg_tap_props.sv
/* Checker on cfg_tap_port pins.
   Assumes clk at 20 MHz and a test clock far slower. */
`timescale 1ns/1ps
`default_nettype none
module cfg_tap_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic recfg_n_pin,
	input wire logic config_done_pin_in,
	input wire logic config_done_pin_out,
	input wire logic config_done_pin_oe,
	input wire logic tck_pin,
	input wire logic tdo_pin_out,
	input wire logic tdo_pin_oe,
	// status
	input wire logic cfg_ready,
	input wire logic configuring,
	input wire logic user_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// done pin only ever pulls low, and only while loading
	property p_od; config_done_pin_out == 1'b0 && config_done_pin_oe == configuring; endproperty
	a_od: assert property (p_od) else $error("done drive wrong");
	// sync delay plus one state step
	property p_hold; !config_done_pin_in [*4] |-> !user_mode; endproperty
	a_hold: assert property (p_hold) else $error("user mode with done low");
	property p_entry; $rose(user_mode) |-> config_done_pin_in && !configuring; endproperty
	a_entry: assert property (p_entry) else $error("early user mode");
	property p_reload; !recfg_n_pin [*8] ##1 recfg_n_pin |-> ##[1:6] configuring; endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	// a low request is no reset of user logic
	property p_nosys; user_mode && !recfg_n_pin && config_done_pin_in |=> user_mode; endproperty
	a_nosys: assert property (p_nosys) else $error("request reset user");
	property p_short; $rose(recfg_n_pin) && $past(recfg_n_pin, 4) && user_mode |-> !configuring [*6]; endproperty
	a_short: assert property (p_short) else $error("short pulse taken");
	property p_fall; $changed(tdo_pin_out) || $changed(tdo_pin_oe) |-> !$past(tck_pin); endproperty
	a_fall: assert property (p_fall) else $error("tdo moved on rise");
	// the queue is flushed on the trigger cycle
	property p_flush; $rose(configuring) |-> !$past(cfg_ready); endproperty
	a_flush: assert property (p_flush) else $error("no flush");
endmodule
bind cfg_tap_port cfg_tap_props cfg_tap_props_inst (.clk(clk), .rst(rst),
	.recfg_n_pin(recfg_n_pin), .config_done_pin_in(config_done_pin_in),
	.config_done_pin_out(config_done_pin_out), .config_done_pin_oe(config_done_pin_oe),
	.tck_pin(tck_pin), .tdo_pin_out(tdo_pin_out), .tdo_pin_oe(tdo_pin_oe),
	.cfg_ready(cfg_ready), .configuring(configuring), .user_mode(user_mode));
`default_nettype wire

// file: testbench/tap_host.sv
/* Test host and config supervisor model.
   Assumes clk at 20 MHz; test clock 400 ns, still between frames. */
`timescale 1ns/1ps
`default_nettype none
module tap_host (
	// clock and resolved tdo wire
	input wire logic clk,
	input wire logic tdo_w,
	// driven pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic recfg_n
);
	// idle levels; pull-ups read as one
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		recfg_n = 1'b1;
	end
	// one period; inputs move with the falling edge
	task automatic step(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		o = tdo_w;
		repeat (4) @(posedge clk);
		tck <= 1'b0;
	endtask
	// five ones reach reset, then idle
	task automatic reset_tap;
		logic b;
		@(posedge clk);
		repeat (5) step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask
	// idle to shift, n bits, back to idle
	task automatic scan(input logic ir, input logic [7:0] v, input int n, output logic [7:0] q);
		logic b;
		q = 8'h00;
		@(posedge clk);
		step(1'b1, 1'b1, b);
		if (ir)
			step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		step(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], b);
			q[i] = b;
		end
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask
	// request low for n cycles, then release
	task automatic pulse(input int n);
		@(posedge clk);
		recfg_n <= 1'b0;
		repeat (n) @(posedge clk);
		recfg_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: testbench/cfg_tap_port_tb.sv
/* Bench for cfg_tap_port.
   Assumes tap_host drives the test and request pins. */
`timescale 1ns/1ps
`default_nettype none
`include "cfg_jtag_map.vh"
module cfg_tap_port_tb;
	logic clk = 1'b0, rst = 1'b1, ext_low = 1'b0, cfg_valid = 1'b0, via = 1'b0;
	logic tdo_last_q = 1'b0;
	logic [7:0] cfg_data = 8'h00;
	logic [7:0] q;
	logic [7:0] img [4] = '{8'h11, 8'h22, 8'h44, 8'h81};
	int n_fail = 0, n_compared = 0;
	wire logic recfg_n, tck, tms, tdi, tdo_out, tdo_oe, done_out, done_oe;
	wire logic cfg_ready, configuring, user_mode;
	// pulled-up done wire; tdo flips when released
	wire logic done_w = !((done_oe && !done_out) || ext_low);
	wire logic tdo_w = tdo_oe ? tdo_out : ~tdo_last_q;
	always @(posedge clk) if (tdo_oe) tdo_last_q <= tdo_out;
	always #25 clk = ~clk;
	cfg_tap_port #(.CFG_WORDS(4), .USER_WAIT(8)) cfg_tap_port_inst (.clk(clk), .rst(rst),
		.recfg_n_pin(recfg_n), .config_done_pin_in(done_w), .config_done_pin_out(done_out),
		.config_done_pin_oe(done_oe), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
		.tdo_pin_out(tdo_out), .tdo_pin_oe(tdo_oe), .cfg_data(cfg_data),
		.cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_via_tap(via),
		.configuring(configuring), .user_mode(user_mode));
	tap_host tap_host_inst (.clk(clk), .tdo_w(tdo_w), .tck(tck), .tms(tms), .tdi(tdi),
		.recfg_n(recfg_n));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded wait for user_mode
	task automatic until_user(input logic v);
		int k;
		for (k = 0; k < 3000 && user_mode !== v; k++)
			@(negedge clk);
		if (k == 3000) begin
			n_fail++;
			results;
		end
	endtask
	// hold each word until the edge that takes it
	task automatic load;
		int k;
		@(posedge clk);
		foreach (img[i]) begin
			cfg_data <= img[i];
			cfg_valid <= 1'b1;
			// look at ready once it has settled, never in the edge's own time step
			@(negedge clk);
			for (k = 0; k < 300 && cfg_ready !== 1'b1; k++)
				@(negedge clk);
			if (k == 300) begin
				n_fail++;
				results;
			end
			@(posedge clk);
		end
		cfg_valid <= 1'b0;
	endtask
	task automatic t_boot;
		chk(done_oe, 1'b1);
		load;
		until_user(1'b1);
		chk(done_w, 1'b1);
		$display("boot done");
	endtask
	// user mode: nothing drains, so the queue refuses when full
	task automatic t_fill;
		int n = 0;
		@(posedge clk);
		cfg_valid <= 1'b1;
		repeat (16) begin
			@(negedge clk);
			n += cfg_ready;
			@(posedge clk);
		end
		cfg_valid <= 1'b0;
		chk(n, 8);
		chk(user_mode, 1'b1);
		$display("fill done");
	endtask
	task automatic t_pulse;
		tap_host_inst.pulse(3);
		repeat (10) @(negedge clk);
		chk(configuring, 1'b0);
		tap_host_inst.pulse(10);
		repeat (6) @(negedge clk);
		chk(configuring, 1'b1);
		repeat (640) @(negedge clk);
		load;
		until_user(1'b1);
		$display("pulse done");
	endtask
	task automatic t_hold;
		@(posedge clk);
		ext_low <= 1'b1;
		until_user(1'b0);
		repeat (50) @(negedge clk);
		chk(user_mode, 1'b0);
		@(posedge clk);
		ext_low <= 1'b0;
		until_user(1'b1);
		$display("hold done");
	endtask
	task automatic t_tap;
		tap_host_inst.reset_tap;
		chk(tdo_oe, 1'b0);
		tap_host_inst.scan(1'b1, {4'h0, `INS_READ_SUM}, 4, q);
		chk(q, {4'h0, `IR_CAPTURE_VAL});
		tap_host_inst.scan(1'b0, 8'h5A, 8, q);
		chk(q, 8'hF6);
		tap_host_inst.scan(1'b1, {4'h0, `INS_BYPASS}, 4, q);
		tap_host_inst.scan(1'b0, 8'h5A, 8, q);
		chk(q, 8'hB4);
		$display("tap done");
	endtask
	task automatic t_via;
		@(posedge clk);
		via <= 1'b1;
		tap_host_inst.pulse(10);
		repeat (640) @(negedge clk);
		load;
		repeat (400) @(negedge clk);
		chk(user_mode, 1'b0);
		tap_host_inst.scan(1'b1, {4'h0, `INS_ENTER_USER}, 4, q);
		until_user(1'b1);
		$display("via done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_boot;
		t_fill;
		t_pulse;
		t_hold;
		t_tap;
		t_via;
		results;
	end
endmodule
`default_nettype wire
